// File: pio_pkg.sv
// Constants, types and register map of the configuration switch decoder.
// Assumes a single 50 MHz clock and switch banks read as 1 for a closed rocker.
`default_nettype none

package pio_pkg;

    // ------------------------------------------------------------------
    // Widths and clock
    // ------------------------------------------------------------------
    localparam int          BANK_A_W      = 8;
    localparam int          BANK_B_W      = 12;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned CLK_PERIOD_NS = 20;

    // ------------------------------------------------------------------
    // Power-up settling time before the banks are captured
    // ------------------------------------------------------------------
    localparam int unsigned SETTLE_NS     = 1000;
    localparam int unsigned SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_BANK_A  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_BANK_B  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h0C;

    // ------------------------------------------------------------------
    // Bank bit positions (rocker n sits in bit n-1)
    // ------------------------------------------------------------------
    localparam int A_FLUSH   = 0;
    localparam int A_SERVICE = 1;
    localparam int A_BURNIN  = 2;
    localparam int A_COLD    = 3;
    localparam int A_LS_SEL  = 5;
    localparam int A_PAR_SEL = 6;
    localparam int A_RECLIM  = 7;
    localparam int B_RECLIM  = 0;
    localparam int B_CODE_MS = 1;
    localparam int B_CODE_MI = 2;
    localparam int B_CODE_LS = 3;
    localparam int B_HEX     = 4;
    localparam int B_CR_VT   = 5;
    localparam int B_CR_FF   = 6;
    localparam int B_CR_LF   = 7;
    localparam int B_LF_CR   = 8;
    localparam int B_CTS     = 6;
    localparam int B_DTR_INV = 7;
    localparam int B_DTR_EN  = 8;
    localparam int B_NO_RESP = 9;
    localparam int B_PAR_OFF = 9;
    localparam int B_BIT8    = 10;
    localparam int B_XON     = 11;
    localparam int B_PI_OFF  = 11;

    // ------------------------------------------------------------------
    // Factory default banks, baud codes, status and control fields
    // ------------------------------------------------------------------
    localparam logic [BANK_A_W-1:0] BANK_A_DEFAULT = 8'h00;
    localparam logic [BANK_B_W-1:0] BANK_B_DEFAULT = 12'hD8A;
    localparam logic [2:0]          BAUD_RESERVED  = 3'h7;
    localparam logic [2:0]          BAUD_FALLBACK  = 3'h5;
    localparam int unsigned         BAUD_RATE [7]  = '{300, 600, 1200, 2400, 4800, 9600, 19200};
    localparam int                  ST_VALID       = 0;
    localparam int                  ST_FLUSH       = 1;
    localparam int                  ST_SERVICE     = 2;
    localparam int                  ST_BURNIN      = 3;
    localparam int                  ST_COLD        = 4;
    localparam int                  ST_HEX         = 5;
    localparam int                  ST_IF_LO       = 6;
    localparam int                  ST_BAUD_LO     = 8;
    localparam int                  ST_BAUD_RSV    = 11;
    localparam int                  CTL_BAUD_RUN   = 0;
    localparam logic                CTL_RESET      = 1'b1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IF_SERIAL     = 2'b00,
        IF_PARALLEL   = 2'b01,
        IF_LONG_SHORT = 2'b10
    } pio_host_if_t;

    typedef enum logic [1:0] {
        SM_SETTLE  = 2'b00,
        SM_CAPTURE = 2'b01,
        SM_RUN     = 2'b10
    } pio_state_t;

    typedef struct packed {
        logic         flush_pages;
        logic         service_mode;
        logic         burn_in;
        logic         cold_start;
        logic         hex_dump;
        pio_host_if_t host_if;
    } pio_mode_t;

    typedef struct packed {
        logic [2:0] baud_code;
        logic       baud_reserved;
        logic       cts_enable;
        logic       dtr_enable;
        logic       dtr_invert;
        logic       no_respond;
        logic       xon_xoff;
    } pio_serial_t;

    typedef struct packed {
        logic [2:0] record_limit;
        logic [2:0] check_delay;
        logic       cr_after_vt;
        logic       cr_after_ff;
        logic       cr_after_lf;
        logic       lf_after_cr;
        logic       parity_check;
        logic       bit8_dedicated;
        logic       pi_enable;
    } pio_ls_t;

endpackage : pio_pkg

`default_nettype wire

// File: pio_switch_decoder.sv
// Power-up decoder for the two configuration switch banks of the formatter.
// Assumes static banks (1 = closed), synchronous inputs and a plain register port.
//
// Operation
// RL1: Bank A rocker 1 closed selects flush-pages behaviour.
// RL2: Bank A rocker 2 closed selects service mode.
// RL3: Burn-in only when bank A rockers 3 and 2 are both closed.
// RL4: Bank A rocker 4 closed requests a cold start at power-up.
// RL5: Serial baud code from bank B rockers 2-4, 300 to 19200 baud.
// RL6: Reserved baud code 111 falls back to 9600 baud.
// RL7: Switch readback shows closed rockers as 1, open as 0.
// RL8: Serial: bank B rocker 7 closed enables CTS flow control.
// RL9: Serial: bank B rocker 9 closed enables DTR handshaking.
// RL10: Serial: bank B rocker 8 inverts DTR polarity when DTR enabled.
// RL11: Serial: bank B rocker 10 closed means no response on errors.
// RL12: Serial: bank B rocker 12 closed enables Xon/Xoff flow control.
// RL13: Bank A rocker 7 closed selects the standard parallel interface.
// RL14: Bank A rocker 6 closed selects long/short-line parallel interface.
// RL15: Bank B rocker 5 closed enables hex dump mode.
// RL16: Long/short: bank A rocker 8 with bank B rocker 1 set record limit.
// RL17: Long/short: bank B rockers 2-4 give demand-to-check delay code.
// RL18: Long/short: bank B rockers 6-8 add CR after VT, FF, LF.
// RL19: Long/short: bank B rocker 9 adds LF after every CR.
// RL20: Long/short: parity checked when bank B rocker 10 open.
// RL21: Long/short: bit 8 from dedicated line when rocker 11 closed.
// RL22: Long/short: paper-instruction function disabled when rocker 12 closed.
// RL23: Banks sampled only once at power-up; changes wait for next power-on.
// RL24: Factory default gives serial interface at 9600 baud.
`default_nettype none

module pio_switch_decoder
    import pio_pkg::*;
#(
    parameter int unsigned CLK_RATE_HZ = pio_pkg::CLK_HZ
) (
    input  wire logic                          clock,
    input  wire logic                          rst,
    input  wire logic [pio_pkg::BANK_A_W-1:0] config_bank_a,
    input  wire logic [pio_pkg::BANK_B_W-1:0] config_bank_b,
    input  wire logic                          paper_instruction_line,
    input  wire logic                          eighth_data_line,
    input  wire logic                          cts_line,
    input  wire logic                          dtr_ready,
    input  wire logic [pio_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [pio_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                          reg_write,
    input  wire logic                          reg_read,
    output var  logic [pio_pkg::DATA_W-1:0]   reg_rdata,
    output var  logic                          config_valid,
    output var  pio_pkg::pio_mode_t            mode,
    output var  pio_pkg::pio_serial_t          serial_cfg,
    output var  pio_pkg::pio_ls_t              ls_cfg,
    output var  logic                          baud_tick,
    output var  logic                          tx_allowed,
    output var  logic                          dtr_line,
    output var  logic                          data_bit8,
    output var  logic                          paper_instr_active
);
    import pio_pkg::*;

    localparam int DIV_W = $clog2(CLK_RATE_HZ / BAUD_RATE[0] + 1);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (CLK_RATE_HZ / BAUD_RATE[6] < 2) begin : g_bad_clock
        $error("CLK_RATE_HZ too low for the fastest baud rate");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pio_state_t                   state;
    logic [15:0]                  settle_cnt;
    logic [BANK_A_W-1:0]          snap_a;
    logic [BANK_B_W-1:0]          snap_b;
    logic                         baud_run;
    logic [DIV_W-1:0]             baud_cnt;
    logic [DIV_W-1:0]             div_tab [7];
    logic [DIV_W-1:0]             next_div;
    pio_host_if_t                 next_if;
    logic [2:0]                   next_code;
    logic                         capture;

    assign capture = (state == SM_CAPTURE);

    // ------------------------------------------------------------------
    // Divider table, one constant per baud code
    // ------------------------------------------------------------------
    for (genvar g = 0; g < 7; g++) begin : g_div
        assign div_tab[g] = DIV_W'(CLK_RATE_HZ / BAUD_RATE[g] - 1);
    end

    // ------------------------------------------------------------------
    // Power-up sequencer
    // ------------------------------------------------------------------
    // RL23 single capture
    always_ff @(posedge clock) begin
        if (rst) begin
            state      <= SM_SETTLE;
            settle_cnt <= 16'h0000;
        end else begin
            unique case (state)
                SM_SETTLE: begin
                    if (settle_cnt == 16'(SETTLE_CYCLES - 1)) begin
                        state <= SM_CAPTURE;
                    end else begin
                        settle_cnt <= settle_cnt + 16'h0001;
                    end
                end
                SM_CAPTURE: begin
                    state <= SM_RUN;
                end
                SM_RUN: begin
                    state <= SM_RUN;
                end
                default: begin
                    state <= SM_SETTLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Snapshot of the banks
    // ------------------------------------------------------------------
    // RL24 factory default
    always_ff @(posedge clock) begin
        if (rst) begin
            snap_a       <= BANK_A_DEFAULT;
            snap_b       <= BANK_B_DEFAULT;
            config_valid <= 1'b0;
        end else if (capture) begin
            snap_a       <= config_bank_a;
            snap_b       <= config_bank_b;
            config_valid <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Decode of the live banks, taken only at capture
    // ------------------------------------------------------------------
    always_comb begin
        // RL13 parallel select
        if (config_bank_a[A_PAR_SEL]) begin
            next_if = IF_PARALLEL;
        // RL14 long/short select
        end else if (config_bank_a[A_LS_SEL]) begin
            next_if = IF_LONG_SHORT;
        end else begin
            next_if = IF_SERIAL;
        end
        next_code = {config_bank_b[B_CODE_MS], config_bank_b[B_CODE_MI], config_bank_b[B_CODE_LS]};
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mode <= '{host_if: IF_SERIAL, default: 1'b0};
        end else if (capture) begin
            // RL1 flush pages
            mode.flush_pages  <= config_bank_a[A_FLUSH];
            // RL2 service mode
            mode.service_mode <= config_bank_a[A_SERVICE];
            // RL3 burn-in gating
            mode.burn_in      <= config_bank_a[A_BURNIN] & config_bank_a[A_SERVICE];
            // RL4 cold start
            mode.cold_start   <= config_bank_a[A_COLD];
            // RL15 hex dump
            mode.hex_dump     <= config_bank_b[B_HEX];
            mode.host_if      <= next_if;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            serial_cfg <= '{baud_code: BAUD_FALLBACK, default: 1'b0};
        end else if (capture) begin
            serial_cfg <= '{baud_code: BAUD_FALLBACK, default: 1'b0};
            if (next_if == IF_SERIAL) begin
                // RL5 baud code
                serial_cfg.baud_code     <= (next_code == BAUD_RESERVED) ? BAUD_FALLBACK : next_code;
                // RL6 reserved fallback
                serial_cfg.baud_reserved <= (next_code == BAUD_RESERVED);
                // RL8 CTS enable
                serial_cfg.cts_enable    <= config_bank_b[B_CTS];
                // RL9 DTR enable
                serial_cfg.dtr_enable    <= config_bank_b[B_DTR_EN];
                // RL10 DTR polarity
                serial_cfg.dtr_invert    <= config_bank_b[B_DTR_EN] & config_bank_b[B_DTR_INV];
                // RL11 error response
                serial_cfg.no_respond    <= config_bank_b[B_NO_RESP];
                // RL12 Xon/Xoff
                serial_cfg.xon_xoff      <= config_bank_b[B_XON];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ls_cfg <= '0;
        end else if (capture) begin
            ls_cfg <= '0;
            if (next_if == IF_LONG_SHORT) begin
                // RL16 record limiting
                unique case ({config_bank_a[A_RECLIM], config_bank_b[B_RECLIM]})
                    2'b00: ls_cfg.record_limit <= 3'h0;
                    2'b01: ls_cfg.record_limit <= 3'h1;
                    2'b10: ls_cfg.record_limit <= 3'h2;
                    2'b11: ls_cfg.record_limit <= 3'h4;
                endcase
                // RL17 check delay
                ls_cfg.check_delay    <= next_code;
                // RL18 auto CR
                ls_cfg.cr_after_vt    <= config_bank_b[B_CR_VT];
                ls_cfg.cr_after_ff    <= config_bank_b[B_CR_FF];
                ls_cfg.cr_after_lf    <= config_bank_b[B_CR_LF];
                // RL19 auto LF
                ls_cfg.lf_after_cr    <= config_bank_b[B_LF_CR];
                // RL20 parity check
                ls_cfg.parity_check   <= ~config_bank_b[B_PAR_OFF];
                // RL21 bit 8 source
                ls_cfg.bit8_dedicated <= config_bank_b[B_BIT8];
                // RL22 PI function
                ls_cfg.pi_enable      <= ~config_bank_b[B_PI_OFF];
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial baud divider
    // ------------------------------------------------------------------
    assign next_div = div_tab[serial_cfg.baud_code];

    // RL5 bit rate
    always_ff @(posedge clock) begin
        if (rst) begin
            baud_cnt  <= '0;
            baud_tick <= 1'b0;
        end else if (!baud_run || !config_valid || mode.host_if != IF_SERIAL) begin
            baud_cnt  <= '0;
            baud_tick <= 1'b0;
        end else if (baud_cnt >= next_div) begin
            baud_cnt  <= '0;
            baud_tick <= 1'b1;
        end else begin
            baud_cnt  <= baud_cnt + DIV_W'(1);
            baud_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Line handling
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            tx_allowed         <= 1'b0;
            dtr_line           <= 1'b0;
            data_bit8          <= 1'b0;
            paper_instr_active <= 1'b0;
        end else begin
            // RL8 CTS gating
            tx_allowed <= config_valid & (~serial_cfg.cts_enable | cts_line);
            // RL10 DTR output
            dtr_line   <= serial_cfg.dtr_enable ? (dtr_ready ^ serial_cfg.dtr_invert) : 1'b0;
            // RL21 bit 8 mux
            data_bit8  <= ls_cfg.bit8_dedicated ? eighth_data_line : paper_instruction_line;
            // RL22 PI gating
            paper_instr_active <= ls_cfg.pi_enable & paper_instruction_line;
        end
    end

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            baud_run <= CTL_RESET;
        end else if (reg_write && reg_addr == OFS_CONTROL) begin
            baud_run <= reg_wdata[CTL_BAUD_RUN];
        end
    end

    // RL7 closed reads one
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= '0;
            if (reg_read) begin
                unique case (reg_addr)
                    OFS_BANK_A:  reg_rdata <= DATA_W'(snap_a);
                    OFS_BANK_B:  reg_rdata <= DATA_W'(snap_b);
                    OFS_STATUS: begin
                        reg_rdata[ST_VALID]                  <= config_valid;
                        reg_rdata[ST_FLUSH]                  <= mode.flush_pages;
                        reg_rdata[ST_SERVICE]                <= mode.service_mode;
                        reg_rdata[ST_BURNIN]                 <= mode.burn_in;
                        reg_rdata[ST_COLD]                   <= mode.cold_start;
                        reg_rdata[ST_HEX]                    <= mode.hex_dump;
                        reg_rdata[ST_IF_LO +: 2]             <= mode.host_if;
                        reg_rdata[ST_BAUD_LO +: 3]           <= serial_cfg.baud_code;
                        reg_rdata[ST_BAUD_RSV]               <= serial_cfg.baud_reserved;
                    end
                    OFS_CONTROL: reg_rdata[CTL_BAUD_RUN] <= baud_run;
                    default:     reg_rdata <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic [15:0] since_rst;
    always_ff @(posedge clock) begin
        if (rst) begin
            since_rst <= 16'h0000;
        end else if (since_rst != 16'hFFFF) begin
            since_rst <= since_rst + 16'h0001;
        end
    end

    chk_capture_moment: assert property ($rose(config_valid) |-> since_rst == 16'(SETTLE_CYCLES + 1)) // RL23
        else $error("capture not at end of settle time");
    chk_config_frozen: assert property (config_valid && $past(config_valid) |-> $stable(mode) && $stable(snap_b)) // RL23
        else $error("configuration changed after capture");
    chk_burnin_service: assert property (mode.burn_in |-> mode.service_mode) // RL3
        else $error("burn-in without service mode");
    chk_baud_fallback: assert property (serial_cfg.baud_reserved |-> serial_cfg.baud_code == BAUD_FALLBACK) // RL6
        else $error("reserved baud code not replaced");
    chk_dtr_gated: assert property (!serial_cfg.dtr_enable |-> !serial_cfg.dtr_invert ##1 !dtr_line) // RL10
        else $error("DTR active while disabled");
    chk_serial_scope: assert property (mode.host_if != IF_SERIAL |-> !serial_cfg.cts_enable && !serial_cfg.xon_xoff) // RL8
        else $error("serial option outside serial card");
    chk_ls_scope: assert property (mode.host_if != IF_LONG_SHORT |-> ls_cfg == '0) // RL18
        else $error("long/short option outside its card");
    chk_record_limit: assert property (ls_cfg.record_limit inside {3'h0, 3'h1, 3'h2, 3'h4}) // RL16
        else $error("illegal record limit");
    chk_bank_readback: assert property (reg_read && reg_addr == OFS_BANK_B && config_valid |=> reg_rdata == DATA_W'(snap_b)) // RL7
        else $error("bank readback wrong");
    chk_tick_spacing: assert property (baud_tick |=> !baud_tick) // RL5
        else $error("baud ticks back to back");

    cov_capture:    cover property ($rose(config_valid));
    cov_burn_in:    cover property (config_valid && mode.burn_in);
    cov_long_short: cover property (config_valid && mode.host_if == IF_LONG_SHORT);
    cov_reserved:   cover property (config_valid && serial_cfg.baud_reserved);

endmodule : pio_switch_decoder

`default_nettype wire

// File: pio_switch_model.sv
// Rocker model: two hand-set switch banks on the formatter board.
// Assumes power_off is high while the board is unpowered.
`default_nettype none
module pio_switch_model (
    input  wire logic                          power_off,
    input  wire logic                          hot_swap,
    input  wire logic [pio_pkg::BANK_A_W-1:0] set_a,
    input  wire logic [pio_pkg::BANK_B_W-1:0] set_b,
    output var  logic [pio_pkg::BANK_A_W-1:0] bank_a,
    output var  logic [pio_pkg::BANK_B_W-1:0] bank_b
);
    timeunit 1ns;
    timeprecision 1ns;
    import pio_pkg::*;
    // closed rocker as 1, moved unpowered or while hot_swap is high
    always @(power_off or hot_swap or set_a or set_b) begin
        if (power_off || hot_swap) begin
            bank_a = set_a;
            bank_b = set_b;
        end
    end
endmodule : pio_switch_model
`default_nettype wire

// File: printer_io_switch_config_decoder_tb.sv
// Bench: boots the decoder with rocker settings and checks the decode.
// Assumes the rocker model holds the banks while powered and hot_swap is low.
`default_nettype none
module printer_io_switch_config_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pio_pkg::*;
    logic clock, rst, hot, pil, edl, cts_line, dtr_ready, reg_write, reg_read;
    logic [7:0] set_a, bank_a, reg_addr;
    logic [11:0] set_b, bank_b;
    logic [31:0] reg_wdata, reg_rdata;
    logic cfg_ok, tick, tx_ok, dtr, bit8, pi_act;
    logic [2:0] lim;
    pio_mode_t mode;
    pio_serial_t ser;
    pio_ls_t ls;
    int mismatches, compares, cycles, n;
    int rate[8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 9600};

    pio_switch_model SW (.power_off(rst), .hot_swap(hot), .set_a(set_a), .set_b(set_b),
        .bank_a(bank_a), .bank_b(bank_b));
    pio_switch_decoder #(.CLK_RATE_HZ(192000)) DUT (.clock(clock), .rst(rst),
        .config_bank_a(bank_a), .config_bank_b(bank_b), .paper_instruction_line(pil),
        .eighth_data_line(edl), .cts_line(cts_line), .dtr_ready(dtr_ready),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .config_valid(cfg_ok), .mode(mode),
        .serial_cfg(ser), .ls_cfg(ls), .baud_tick(tick), .tx_allowed(tx_ok),
        .dtr_line(dtr), .data_bit8(bit8), .paper_instr_active(pi_act));

    always #10 clock = ~clock;

    task automatic wrap_up();
        if (mismatches == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic boot(input logic [7:0] a, input logic [11:0] b);
        int i;
        @(posedge clock);
        rst <= 1'h1;
        set_a <= a;
        set_b <= b;
        repeat (12) @(posedge clock);
        rst <= 1'h0;
        for (i = 0; i < 60 && cfg_ok !== 1'h1; i++) @(negedge clock);
        check(i, SETTLE_CYCLES + 2);
        @(negedge clock);
    endtask : boot

    task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= ad;
        reg_read <= 1'h1;
        @(posedge clock);
        reg_read <= 1'h0;
        @(negedge clock);
        check(reg_rdata, exp);
    endtask : rd

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge clock);
        reg_write <= 1'h0;
    endtask : wr

    task automatic tick_gap(input int exp);
        int i;
        for (i = 0; i < 2000 && tick !== 1'h1; i++) @(negedge clock);
        @(negedge clock);
        for (n = 1; n < 2000 && tick !== 1'h1; n++) @(negedge clock);
        check(n, exp);
    endtask : tick_gap

    initial begin
        {clock, hot, pil, edl, cts_line, reg_write, reg_read, reg_addr, reg_wdata} = '0;
        {rst, dtr_ready} = 2'h3;
        {set_a, set_b, mismatches, compares, cycles} = '0;
        boot(8'h00, 12'hD8A);
        check(ser, 9'h14D);
        check(mode, 7'h00);
        check({tx_ok, dtr}, 2'h2);
        @(posedge clock) dtr_ready <= 1'h0;
        repeat (2) @(negedge clock);
        check(dtr, 1'h1);
        rd(OFS_BANK_B, 32'h00000D8A);
        rd(8'h10, 32'h00000000);
        boot(8'h0F, 12'h000);
        check(mode, 7'h78);
        boot(8'h05, 12'h000);
        check(mode, 7'h40);
        boot(8'h00, 12'h2C0);
        check(ser, 9'h012);
        check({tx_ok, dtr}, 2'h0);
        @(posedge clock) cts_line <= 1'h1;
        repeat (2) @(negedge clock);
        check(tx_ok, 1'h1);
        for (int c = 0; c < 8; c++) begin
            boot(8'h00, {8'h80, c[0], c[1], c[2], 1'h0});
            check(ser[8:5], {(c == 7) ? 3'h5 : 3'(c), c == 7});
            check(ser[2:0], 3'h1);
            tick_gap(192000 / rate[c]);
        end
        boot(8'h40, 12'h010);
        check(mode, 7'h05);
        for (int r = 0; r < 4; r++) begin
            @(posedge clock) {pil, edl} <= 2'h2;
            lim = (r == 3) ? 3'h4 : 3'(r);
            boot({r[1], 7'h20}, (r > 1) ? 12'(r & 1) : 12'hFE8 | 12'(r));
            check(mode.host_if, IF_LONG_SHORT);
            check(ls, r[1] ? {lim, 7'h00, 3'h5} : {lim, 3'h1, 4'hF, 3'h2});
            check({bit8, pi_act}, {r[1], r[1]});
        end
        boot(8'h00, 12'hD8A);
        hot <= 1'h1;
        set_a <= 8'hFF;
        wr(OFS_BANK_A, 32'h000000FF);
        @(negedge clock);
        check(mode, 7'h00);
        rd(OFS_BANK_A, 32'h00000000);
        wr(OFS_CONTROL, 32'h00000000);
        n = 0;
        repeat (60) @(negedge clock) n += tick;
        check(n, 0);
        wr(OFS_CONTROL, 32'h00000001);
        tick_gap(20);
        wrap_up();
    end
endmodule : printer_io_switch_config_decoder_tb
`default_nettype wire
